/* common/membus_pkg.sv */
// package: constants and carrier types for the backplane memory bus master port
package membus_pkg;

   // bus widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int CHECK_W = 7;
   localparam int LANES = 4;

   // bus clock rate and system clock rate, in MHz
   localparam int BUS_CLK_MHZ = 25;
   localparam int BOARD_SYSTEM_CLOCK_MHZ = 100;
   // system clocks per bus clock period
   localparam int BUS_PERIOD_CYC = BOARD_SYSTEM_CLOCK_MHZ / BUS_CLK_MHZ;

   // lane select values: none at reset, all for reads
   localparam logic [3:0] LANES_NONE = 4'h0;
   localparam logic [3:0] LANES_ALL = 4'hf;

   // master port states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_REQUEST = 3'b001,
      ST_DRIVE = 3'b010,
      ST_FAULT = 3'b011,
      ST_DONE = 3'b100
   } port_state_t;

   // a processor-side request
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lanes;
      logic rd;
      logic [DATA_W-1:0] wdata;
      logic [CHECK_W-1:0] wcheck;
   } cpu_req_t;

   // what the board puts onto the bus
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lanes;
      logic rd;
      logic [DATA_W-1:0] data;
      logic [CHECK_W-1:0] check;
   } bus_drive_t;

   // returns true when the set bits form one contiguous run of 1..4 lanes
   function automatic logic lanes_contiguous(input logic [3:0] l);
      unique case (l)
         4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

endpackage

/* hdl/bus_clock_sync.sv */
// file: bus clock pair sampler producing a rising-edge enable
`timescale 1ns/1ps
module bus_clock_sync
   import membus_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // differential bus clock pins
   input wire logic clk_true,
   input wire logic clk_comp,
   // one-cycle pulse on each bus clock rising edge
   output logic tick
);

   // sync chain state, all in one struct
   typedef struct packed
   {
      logic [2:0] t_sh;
      logic [2:0] c_sh;
      logic level;
      logic tick;
      logic primed; // a first valid level has been seen since reset
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   // stage three and two agree, and true differs from complement: a valid level
   always_comb
   begin
      st_next = st_reg;
      st_next.t_sh = {st_reg.t_sh[1:0], clk_true};
      st_next.c_sh = {st_reg.c_sh[1:0], clk_comp};
      st_next.tick = 1'b0;
      // a glitch that lets both halves agree is ignored, keeping the last level
      if (st_reg.t_sh[2] == st_reg.t_sh[1] && st_reg.c_sh[2] == st_reg.c_sh[1]
          && st_reg.t_sh[2] != st_reg.c_sh[2])
      begin
         st_next.level = st_reg.t_sh[2];
         // no tick on the first valid level after reset: it may sit mid-period
         st_next.tick = st_reg.primed & st_reg.t_sh[2] & ~st_reg.level;
         st_next.primed = 1'b1;
      end
   end

   // register the state
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign tick = st_reg.tick;

   // tick never on two cycles running
   chk_tick_single: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ1]
      tick |=> !tick) else $error("bus clock tick lasted two cycles");

endmodule // bus_clock_sync

/* hdl/membus_master.sv */
// file: processor memory bus master port of the cpu board
`timescale 1ns/1ps
// Behaviour
// (RQ1) bus timed by 25 MHz differential clock
// (RQ2) request bus; drive only after grant
// (RQ3) drive 24-bit long-word address
// (RQ4) four contiguous byte lane selects
// (RQ5) memory keeps unselected bytes on writes
// (RQ6) all lanes on write: fast write
// (RQ7) partial lanes on write: read-modify-write
// (RQ8) reads assert all four lane selects
// (RQ9) read indication valid with address
// (RQ10) cycle done during last bus period
// (RQ11) sample error lines while cycle done
// (RQ12) corrected error line ignored by board
// (RQ13) uncorrectable error gives next-cycle bus error; the board raises it on reads only
// (RQ14) 32 data bits plus seven check bits
// (RQ15) memory go line unused by board
// (RQ16) hold bus stable until cycle done
module membus_master
   import membus_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // differential bus clock
   input wire logic BUS_CLK_P,
   input wire logic BUS_CLK_N,
   // processor side
   input wire logic CPU_REQ_VALID,
   input wire cpu_req_t CPU_REQ,
   output logic CPU_REQ_READY,
   output logic CPU_DONE,
   output logic [DATA_W-1:0] CPU_RDATA,
   output logic [CHECK_W-1:0] CPU_RCHECK,
   output logic CPU_BUS_ERROR,
   output logic CPU_BAD_LANES,
   // arbitration
   output logic BUS_REQUEST,
   input wire logic BUS_GRANT,
   // address and lanes as three-signal pins, read indication as output and enable only
   input wire logic [ADDR_W-1:0] ADDR_IN,
   output logic [ADDR_W-1:0] ADDR_OUT,
   output logic ADDR_OE,
   input wire logic [LANES-1:0] LANE_SEL_IN,
   output logic [LANES-1:0] LANE_SEL_OUT,
   output logic LANE_SEL_OE,
   output logic READ_IND,
   output logic READ_IND_OE,
   // data and check bits
   input wire logic [DATA_W-1:0] DATA_IN,
   output logic [DATA_W-1:0] DATA_OUT,
   output logic DATA_OE,
   input wire logic [CHECK_W-1:0] CHECK_IN,
   output logic [CHECK_W-1:0] CHECK_OUT,
   output logic CHECK_OE,
   // cycle end and error lines from the memory controller
   input wire logic CYCLE_DONE,
   input wire logic CORRECTED_ERROR,
   input wire logic UNCORRECTABLE_ERROR,
   input wire logic MEMORY_GO
);

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers

   // three-stage chains for the off-domain controller lines
   typedef struct packed
   {
      logic [2:0] grant;
      logic [2:0] done;
      logic [2:0] uc;
   } pin_sync_t;

   // whole port state
   typedef struct packed
   {
      port_state_t state;
      pin_sync_t sy;
      logic grant_q; // agreed grant level
      logic done_q; // agreed cycle done level
      bus_drive_t drv; // held bus image
      logic oe;
      logic request;
      logic uc_latched;
      logic [DATA_W-1:0] rdata;
      logic [CHECK_W-1:0] rcheck;
      logic cpu_done;
      logic bus_error;
      logic bad_lanes;
      logic reported; // done pulse already given for this transfer
   } master_state_t;

   master_state_t st_reg;
   master_state_t st_next;
   logic bus_tick; // rising edge of the bus clock

   // the bus clock edge paces arbitration, keeping requests aligned to it
   bus_clock_sync u_clk_sync
   (
      .CLK(CLK),
      .RESET_N(RESET_N),
      .clk_true(BUS_CLK_P),
      .clk_comp(BUS_CLK_N),
      .tick(bus_tick)
   ); // [RQ1]

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb
   begin
      st_next = st_reg;
      st_next.sy.grant = {st_reg.sy.grant[1:0], BUS_GRANT};
      st_next.sy.done = {st_reg.sy.done[1:0], CYCLE_DONE};
      st_next.sy.uc = {st_reg.sy.uc[1:0], UNCORRECTABLE_ERROR};
      // a level counts once stages two and three agree
      if (st_reg.sy.grant[2] == st_reg.sy.grant[1])
         st_next.grant_q = st_reg.sy.grant[2];
      if (st_reg.sy.done[2] == st_reg.sy.done[1])
         st_next.done_q = st_reg.sy.done[2];
      st_next.cpu_done = 1'b0;
      st_next.bus_error = 1'b0;
      st_next.bad_lanes = 1'b0;
      unique case (st_reg.state)
         ST_IDLE:
         begin
            // capture a request; reads always fetch the whole long word
            if (CPU_REQ_VALID)
            begin
               st_next.drv.addr = CPU_REQ.addr; // [RQ3]
               st_next.drv.rd = CPU_REQ.rd;
               st_next.drv.lanes = CPU_REQ.rd ? LANES_ALL : CPU_REQ.lanes; // [RQ8]
               st_next.drv.data = CPU_REQ.wdata; // [RQ14]
               st_next.drv.check = CPU_REQ.wcheck;
               st_next.uc_latched = 1'b0;
               st_next.reported = 1'b0;
               // a broken lane pattern never reaches the bus
               if (!CPU_REQ.rd && !lanes_contiguous(CPU_REQ.lanes)) // [RQ4]
               begin
                  st_next.bad_lanes = 1'b1;
                  st_next.cpu_done = 1'b1;
               end
               else
                  st_next.state = ST_REQUEST;
            end
         end
         ST_REQUEST:
         begin
            // raise the request on a bus clock edge, drive only once granted
            if (bus_tick)
               st_next.request = 1'b1;
            if (st_reg.request && st_reg.grant_q)
            begin
               st_next.oe = 1'b1; // [RQ2]
               st_next.state = ST_DRIVE;
            end
         end
         ST_DRIVE:
         begin
            // image held unchanged; sample errors and read data with cycle done
            if (st_reg.done_q)
            begin
               st_next.uc_latched = st_reg.sy.uc[2]; // [RQ11]
               st_next.rdata = DATA_IN;
               st_next.rcheck = CHECK_IN;
               st_next.oe = 1'b0; // [RQ16]
               st_next.request = 1'b0;
               st_next.state = (st_reg.sy.uc[2] && st_reg.drv.rd) ? ST_FAULT : ST_DONE;
            end
         end
         ST_FAULT:
         begin
            // uncorrectable read error reported on the cycle after the failing one
            st_next.bus_error = 1'b1; // [RQ13]
            st_next.cpu_done = 1'b1;
            st_next.reported = 1'b1;
            st_next.state = ST_DONE;
         end
         ST_DONE:
         begin
            // exactly one done pulse per transfer; the fault state gives its own
            if (!st_reg.reported)
            begin
               st_next.cpu_done = 1'b1;
               st_next.reported = 1'b1;
            end
            st_next.uc_latched = 1'b0;
            // wait for cycle done and grant to drop before a new request
            if (st_reg.reported && !st_reg.done_q && !st_reg.grant_q)
               st_next.state = ST_IDLE;
         end
         default:
            st_next.state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         st_reg <= '0;
         st_reg.state <= ST_IDLE;
         st_reg.drv.lanes <= LANES_NONE;
      end
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; address, lanes and read indication share one enable

   assign CPU_REQ_READY = (st_reg.state == ST_IDLE);
   assign CPU_DONE = st_reg.cpu_done;
   assign CPU_RDATA = st_reg.rdata;
   assign CPU_RCHECK = st_reg.rcheck;
   assign CPU_BUS_ERROR = st_reg.bus_error;
   assign CPU_BAD_LANES = st_reg.bad_lanes;
   assign BUS_REQUEST = st_reg.request;
   assign ADDR_OUT = st_reg.drv.addr;
   assign ADDR_OE = st_reg.oe;
   assign LANE_SEL_OUT = st_reg.drv.lanes;
   assign LANE_SEL_OE = st_reg.oe;
   assign READ_IND = st_reg.drv.rd;
   assign READ_IND_OE = st_reg.oe; // [RQ9]
   assign DATA_OUT = st_reg.drv.data;
   assign DATA_OE = st_reg.oe & ~st_reg.drv.rd;
   assign CHECK_OUT = st_reg.drv.check;
   assign CHECK_OE = st_reg.oe & ~st_reg.drv.rd;
   // corrected error, memory go and the echoed address and lanes are not used:
   // the board only watches lines it must act on
   // [RQ12] [RQ15]

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // grant seen while still asking: the drive starts on the next edge
   sequence s_granted;
      st_reg.state == ST_REQUEST && st_reg.request && st_reg.grant_q;
   endsequence

   chk_drive_after_grant: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ2]
      $rose(ADDR_OE) |-> $past(st_reg.grant_q) && BUS_REQUEST)
      else $error("bus driven without grant");
   chk_read_all_lanes: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ8]
      (ADDR_OE && READ_IND) |-> LANE_SEL_OUT == LANES_ALL)
      else $error("read without all lanes");
   chk_lanes_contig: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ4]
      ADDR_OE |-> lanes_contiguous(LANE_SEL_OUT))
      else $error("non contiguous lanes on bus");
   chk_read_with_addr: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ9]
      READ_IND_OE == ADDR_OE) else $error("read indication not with address");
   chk_hold_stable: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ16]
      (ADDR_OE && $past(ADDR_OE)) |-> $stable(ADDR_OUT) && $stable(LANE_SEL_OUT)
      && $stable(DATA_OUT)) else $error("bus image changed while driven");
   chk_release_on_done: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ16]
      (st_reg.state == ST_DRIVE && st_reg.done_q) |=> !ADDR_OE && !BUS_REQUEST)
      else $error("bus not released after cycle done");
   chk_uc_bus_error: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ13]
      (st_reg.state == ST_DRIVE && st_reg.done_q && st_reg.sy.uc[2] && READ_IND)
      |=> ##1 CPU_BUS_ERROR) else $error("missing bus error after uncorrectable read");
   chk_no_spurious_error: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ11]
      CPU_BUS_ERROR |-> $past(st_reg.state) == ST_FAULT)
      else $error("bus error without latched fault");
   chk_data_width: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ14]
      s_granted |=> ADDR_OE && DATA_OE == !READ_IND && CHECK_OE == DATA_OE)
      else $error("write data not driven");
   chk_tick_request: assert property (@(posedge CLK) disable iff (!RESET_N) // [RQ1]
      $rose(BUS_REQUEST) |-> $past(bus_tick)) else $error("request off bus clock edge");

endmodule // membus_master

/* verification/mem_ctrl_model.sv */
// file: behavioural memory controller and memory board facing the bus master port
`timescale 1ns/1ps
module mem_ctrl_model
   import membus_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bus side
   output logic bclk,
   output logic grant,
   output logic done,
   output logic uncorrectable_error,
   output logic [DATA_W-1:0] rdata,
   output logic [CHECK_W-1:0] rcheck,
   input wire logic req,
   input wire bus_drive_t drv,
   input wire logic oe,
   // scenario controls
   input wire logic inject_uc,
   input wire logic [31:0] grant_wait,
   // what the port put on the bus, and any early or unsteady drive
   output bus_drive_t seen,
   output logic bad_hold
);
   logic [DATA_W-1:0] md [int]; // sparse memory words
   logic [CHECK_W-1:0] mc [int]; // check bits kept beside each word
   // free-running bus clock pair, 40 ns period
   initial bclk = 1'b0;
   always #20 bclk = ~bclk;
   // one memory cycle per request, all changes just after a falling edge
   initial
   begin
      {grant, done, uncorrectable_error, bad_hold, seen} = '0;
      {rdata, rcheck} = '1;
      forever
      begin
         @(negedge clk);
         // any drive without a grant is a breach
         if (oe && !grant)
            bad_hold = 1'b1;
         if (req && reset_n)
         begin
            for (int w = 0; w < grant_wait; w++)
            begin
               @(negedge clk);
               if (oe)
                  bad_hold = 1'b1;
            end
            grant = 1'b1;
            while (!oe) @(negedge clk);
            seen = drv;
            if (!md.exists(drv.addr))
            begin
               md[drv.addr] = '0;
               mc[drv.addr] = '0;
            end
            // fast write and read-modify-write give the same image here
            for (int i = 0; i < LANES; i++)
               if (!drv.rd && drv.lanes[i])
                  md[drv.addr][8*i +: 8] = drv.data[8*i +: 8];
            if (!drv.rd)
               mc[drv.addr] = drv.check;
            else
               {rdata, rcheck} = {md[drv.addr], mc[drv.addr]};
            // done stretched so the port's three-flop sampler surely sees it
            for (int k = 0; k < 2 + 2 * BUS_PERIOD_CYC; k++)
            begin
               @(negedge clk);
               if (k == 2)
                  {done, uncorrectable_error} = {1'b1, inject_uc};
               // the image must stay as captured while driven
               if (oe && drv !== seen)
                  bad_hold = 1'b1;
            end
            while (oe) @(negedge clk);
            {done, uncorrectable_error, grant} = '0;
            {rdata, rcheck} = ~{rdata, rcheck}; // data drops with done
         end
      end
   end
endmodule // mem_ctrl_model

/* verification/membus_master_tb.sv */
// file: self-checking testbench of the bus master port
`timescale 1ns/1ps
module membus_master_tb
   import membus_pkg::*;
;
   logic clk = 1'b0, reset_n = 1'b0, valid = 1'b0, corr = 1'b0, go = 1'b0, uc = 1'b0;
   logic ready, cdone, berr, badl, breq, grant, mdone, muc, bclk, split = 1'b0;
   logic aoe, loe, rioe, doe, coe, rind;
   cpu_req_t rq = '0;
   logic [ADDR_W-1:0] aout;
   logic [LANES-1:0] lout;
   logic [DATA_W-1:0] dout, mdat, crd, g_data;
   logic [CHECK_W-1:0] cout, mcb, crc, g_cb;
   logic g_err, g_bad, bad_hold;
   bus_drive_t seen;
   int n_fail = 0, n_tests = 0, gw = 1, req_cnt = 0;
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   membus_master dut_u (.CLK(clk), .RESET_N(reset_n), .BUS_CLK_P(bclk), .BUS_CLK_N(~bclk),
      .CPU_REQ_VALID(valid), .CPU_REQ(rq), .CPU_REQ_READY(ready), .CPU_DONE(cdone),
      .CPU_RDATA(crd), .CPU_RCHECK(crc), .CPU_BUS_ERROR(berr), .CPU_BAD_LANES(badl),
      .BUS_REQUEST(breq), .BUS_GRANT(grant), .ADDR_IN(aoe ? aout : ~aout), .ADDR_OUT(aout),
      .ADDR_OE(aoe), .LANE_SEL_IN(loe ? lout : ~lout), .LANE_SEL_OUT(lout), .LANE_SEL_OE(loe),
      .READ_IND(rind), .READ_IND_OE(rioe), .DATA_IN(doe ? dout : mdat), .DATA_OUT(dout),
      .DATA_OE(doe), .CHECK_IN(coe ? cout : mcb), .CHECK_OUT(cout), .CHECK_OE(coe),
      .CYCLE_DONE(mdone), .CORRECTED_ERROR(corr), .UNCORRECTABLE_ERROR(muc), .MEMORY_GO(go));
   mem_ctrl_model mem_u (.clk(clk), .reset_n(reset_n), .bclk(bclk), .grant(grant),
      .done(mdone), .uncorrectable_error(muc), .rdata(mdat), .rcheck(mcb), .req(breq),
      .drv({aout, lout, rind, dout, cout}), .oe(aoe), .inject_uc(uc), .grant_wait(gw),
      .seen(seen), .bad_hold(bad_hold));
   // watch that all address-phase enables move together, and any bus request
   always @(negedge clk)
   begin
      split <= split | (aoe !== rioe) | (aoe !== loe) | (coe !== doe) | (doe !== (aoe & ~rind));
      req_cnt <= req_cnt + int'(breq === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one transfer: request held until taken, then bounded waits for done and ready
   task automatic xfer(input logic [23:0] a, input logic [3:0] l, input logic r,
      input logic [31:0] d, input logic [6:0] c);
      int k;
      @(negedge clk);
      valid = 1'b1;
      rq = '{a, l, r, d, c};
      // ready seen high at a falling edge: the next rising edge takes the request
      while (ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      valid = 1'b0;
      for (k = 0; k < 400 && cdone !== 1'b1; k++) @(negedge clk);
      check("cpu done", cdone, 1'b1);
      {g_err, g_bad, g_data, g_cb} = {berr, badl, crd, crc};
      for (k = 0; k < 400 && ready !== 1'b1; k++) @(negedge clk);
      check("ready back", ready, 1'b1);
   endtask
   task automatic t_full();
      xfer(24'h000123, 4'hf, 1'b0, 32'h11223344, 7'h2a);
      check("write lanes", seen.lanes, 4'hf);
      check("write side", {seen.addr, seen.rd, seen.data, seen.check},
         {24'h000123, 1'b0, 32'h11223344, 7'h2a});
      xfer(24'h000123, 4'h3, 1'b1, 32'h0, 7'h0);
      check("read lanes", seen.lanes, 4'hf);
      check("read side", {seen.addr, seen.rd}, {24'h000123, 1'b1});
      check("read data", {g_data, g_cb, g_err}, {32'h11223344, 7'h2a, 1'b0});
      $display("test full word done");
   endtask
   // every contiguous lane group leaves the other bytes alone
   task automatic t_lanes();
      logic [3:0] tbl [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he};
      logic [31:0] img;
      img = 32'h0;
      xfer(24'h000200, 4'hf, 1'b0, img, 7'h00);
      foreach (tbl[i])
      begin
         for (int b = 0; b < 4; b++)
            if (tbl[i][b])
               img[8*b +: 8] = 8'(i + 1);
         xfer(24'h000200, tbl[i], 1'b0, {4{8'(i + 1)}}, 7'h11);
         check("lanes on bus", {seen.lanes, g_bad}, {tbl[i], 1'b0});
         xfer(24'h000200, 4'hf, 1'b1, 32'h0, 7'h0);
         check("merged word", g_data, img);
      end
      $display("test lane groups done");
   endtask
   // gapped or empty lane sets are refused without touching the bus
   task automatic t_refuse();
      logic [3:0] tbl [3] = '{4'h5, 4'h9, 4'h0};
      int c0;
      foreach (tbl[i])
      begin
         c0 = req_cnt;
         xfer(24'h000300, tbl[i], 1'b0, 32'hdeadbeef, 7'h01);
         check("refused", {g_bad, req_cnt != c0}, 2'b10);
      end
      $display("test refused lanes done");
   endtask
   // error lines with a slow grant; memory go and corrected error toggled as noise
   task automatic t_err();
      gw = 20;
      {uc, corr, go} = 3'b011;
      xfer(24'h000123, 4'hf, 1'b1, 32'h0, 7'h0);
      check("corrected only", {g_err, g_bad}, 2'b00);
      uc = 1'b1;
      xfer(24'h000123, 4'hf, 1'b1, 32'h0, 7'h0);
      check("uncorrectable read", g_err, 1'b1);
      xfer(24'h000124, 4'hf, 1'b0, 32'h5, 7'h0);
      check("uncorrectable write", g_err, 1'b0);
      {uc, corr, go, gw} = {3'b000, 32'd1};
      xfer(24'h000123, 4'hf, 1'b1, 32'h0, 7'h0);
      check("error cleared", {g_err, g_data}, {1'b0, 32'h11223344});
      $display("test error lines done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog sized well past the several hundred cycles the tests need
   initial
   begin
      #150000;
      n_fail++;
      print_verdict();
   end
   // main sequence
   initial
   begin
      repeat (8) @(negedge clk);
      check("reset outputs", {ready, breq, aoe, doe, cdone}, 5'b10000);
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      t_full();
      t_lanes();
      t_refuse();
      t_err();
      check("bus hold", {bad_hold, split}, 2'b00);
      print_verdict();
   end
endmodule // membus_master_tb
